// ==== include/obd_cfg.svh ====
// Option byte map, factory values and decode constants.
// Assumes byte-wide option storage addressed as in the option area.
`ifndef OBD_CFG_SVH
`define OBD_CFG_SVH

// ----------------------------------------
// Option byte addresses
// ----------------------------------------
`define OBD_ADDR_READOUT 16'h4800
`define OBD_ADDR_BOOTSIZE 16'h4802
`define OBD_ADDR_RESERVED 16'h4807
`define OBD_ADDR_WATCHDOG 16'h4808
`define OBD_ADDR_OSC 16'h4809
`define OBD_ADDR_BROWNOUT 16'h480A
`define OBD_ADDR_BSEL_LO 16'h480B
`define OBD_ADDR_BSEL_HI 16'h480C

// ----------------------------------------
// Factory values
// ----------------------------------------
`define OBD_RST_READOUT 8'hAA
`define OBD_RST_BOOTSIZE 8'h00
`define OBD_RST_WATCHDOG 4'h0
`define OBD_RST_OSC 4'h0
`define OBD_RST_BROWNOUT 4'h0
`define OBD_RST_BSEL 16'h0000

// ----------------------------------------
// Field positions and decode values
// ----------------------------------------
`define OBD_WD_IHW 0
`define OBD_WD_IHALT 1
`define OBD_WD_WHW 2
`define OBD_WD_WHALT 3
`define OBD_BO_EN 0
`define OBD_BO_LVL_HI 3
`define OBD_BO_LVL_LO 1
`define OBD_UNLOCK_VALUE 8'hAA
`define OBD_SIZE_ALL 8'h7F
`define OBD_PAGES 128
`define OBD_SETTLE_0 13'h0001
`define OBD_SETTLE_1 13'h0010
`define OBD_SETTLE_2 13'h0200
`define OBD_SETTLE_3 13'h1000

// ----------------------------------------
// Unlock keys and boot check (arbitrary values)
// ----------------------------------------
`define OBD_KEY_FIRST 8'h5A
`define OBD_KEY_SECOND 8'hA5
`define OBD_BOOT_KEY 16'h55AA
`define OBD_VECTOR_VALID 8'h82

`endif

// ==== include/obd_pkg.sv ====
// Types shared by the option byte decoder and its users.
// Assumes obd_cfg.svh is on the include path.
package obd_pkg;

  typedef struct packed {
    logic indep_dog_hw_start;
    logic indep_dog_halt_stop;
    logic window_dog_hw_start;
    logic window_dog_halt_reset;
  } obd_dog_type;

  typedef struct packed {
    logic [12:0] fast_osc_settle_count;
    logic [12:0] slow_osc_settle_count;
  } obd_osc_type;

  typedef struct packed {
    logic brownout_enable;
    logic [2:0] brownout_level;
  } obd_bor_type;

  typedef enum logic [1:0] {
    OBD_KEY_IDLE,
    OBD_KEY_HALF,
    OBD_KEY_OPEN
  } obd_key_state_type;

  typedef struct packed {
    logic [7:0] readout_lock_option;
    logic [7:0] boot_area_size_option;
    logic [3:0] watchdog_option;
    logic [3:0] oscillator_settle_option;
    logic [3:0] brownout_option;
    logic [15:0] boot_select_option;
    logic [7:0] readout_lock_live;
    logic [7:0] boot_area_size_live;
    obd_key_state_type key_state;
    logic [7:0] rdata;
    logic readout_protect;
    logic [127:0] boot_protect;
    logic main_locked;
    obd_dog_type dog;
    obd_osc_type osc;
    obd_bor_type bor;
    logic boot_decided;
    logic boot_to_loader;
  } obd_state_type;

endpackage

// ==== verilog/obd_option_decoder.sv ====
// Option byte store and decoder: holds the option bytes and drives
// the decoded settings to protection, watchdog, clock and reset logic.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/1ps
`include "obd_cfg.svh"

module obd_option_decoder
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic opt_wr,
  input wire logic opt_rd,
  input wire logic [15:0] opt_addr,
  input wire logic [7:0] opt_wdata,
  input wire logic opt_from_debug,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic main_relock,
  input wire logic [7:0] reset_vector_byte,
  output logic [7:0] opt_rdata,
  output logic readout_protect,
  output logic [127:0] boot_protect,
  output logic main_locked,
  output obd_pkg::obd_dog_type dog_cfg,
  output obd_pkg::obd_osc_type osc_cfg,
  output obd_pkg::obd_bor_type bor_cfg,
  output logic boot_decided,
  output logic boot_to_loader
);

  obd_pkg::obd_state_type st;
  obd_pkg::obd_state_type next_st;
  logic [7:0] next_pages;
  logic [127:0] next_mask;
  logic [6:0] opt_hit;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [12:0] settle_cycles(input logic [1:0] code);
    logic [12:0] n;
    n = `OBD_SETTLE_0;
    case (code)
      2'h0: n = `OBD_SETTLE_0;
      2'h1: n = `OBD_SETTLE_1;
      2'h2: n = `OBD_SETTLE_2;
      default: n = `OBD_SETTLE_3;
    endcase
    return n;
  endfunction

  function automatic logic [7:0] page_count(input logic [7:0] size);
    logic [7:0] n;
    n = size;
    if (size >= `OBD_SIZE_ALL)
    begin
      n = 8'(`OBD_PAGES);
    end
    return n;
  endfunction

  // Byte select for the option address, one bit per stored byte
  function automatic logic [6:0] opt_select(input logic [15:0] addr);
    logic [6:0] sel;
    sel = 7'h00;
    if (addr == `OBD_ADDR_READOUT)
    begin
      sel = 7'h01;
    end
    else if (addr == `OBD_ADDR_BOOTSIZE)
    begin
      sel = 7'h02;
    end
    else if (addr == `OBD_ADDR_WATCHDOG)
    begin
      sel = 7'h04;
    end
    else if (addr == `OBD_ADDR_OSC)
    begin
      sel = 7'h08;
    end
    else if (addr == `OBD_ADDR_BROWNOUT)
    begin
      sel = 7'h10;
    end
    else if (addr == `OBD_ADDR_BSEL_LO)
    begin
      sel = 7'h20;
    end
    else if (addr == `OBD_ADDR_BSEL_HI)
    begin
      sel = 7'h40;
    end
    return sel;
  endfunction

  // ----------------------------------------
  // Page protection mask
  // ----------------------------------------
  assign next_pages = page_count(st.boot_area_size_live);
  assign opt_hit = opt_select(opt_addr);

  genvar gi;
  generate
    for (gi = 0; gi < `OBD_PAGES; gi = gi + 1)
    begin : g_page
      // Page protected when it lies below the boot area size; a size of 0x7F or more protects all 128 pages
      assign next_mask[gi] = (8'(gi) < next_pages);
    end
  endgenerate

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    // Option byte writes
    if (opt_wr)
    begin
      if (opt_hit[0])
      begin
        next_st.readout_lock_option = opt_wdata;
        if (opt_from_debug)
        begin
          next_st.readout_lock_live = opt_wdata;
        end
      end
      else if (opt_hit[1])
      begin
        next_st.boot_area_size_option = opt_wdata;
        if (opt_from_debug)
        begin
          next_st.boot_area_size_live = opt_wdata;
        end
      end
      else if (opt_hit[2])
      begin
        next_st.watchdog_option = opt_wdata[3:0];
      end
      else if (opt_hit[3])
      begin
        next_st.oscillator_settle_option = opt_wdata[3:0];
      end
      else if (opt_hit[4])
      begin
        next_st.brownout_option = opt_wdata[3:0];
      end
      else if (opt_hit[5])
      begin
        next_st.boot_select_option[15:8] = opt_wdata;
      end
      else if (opt_hit[6])
      begin
        next_st.boot_select_option[7:0] = opt_wdata;
      end
    end
    // Option byte reads; reserved and unmapped read as zero
    if (opt_rd)
    begin
      if (opt_hit[0])
      begin
        next_st.rdata = st.readout_lock_option;
      end
      else if (opt_hit[1])
      begin
        next_st.rdata = st.boot_area_size_option;
      end
      else if (opt_hit[2])
      begin
        next_st.rdata = {4'h0, st.watchdog_option};
      end
      else if (opt_hit[3])
      begin
        next_st.rdata = {4'h0, st.oscillator_settle_option};
      end
      else if (opt_hit[4])
      begin
        next_st.rdata = {4'h0, st.brownout_option};
      end
      else if (opt_hit[5])
      begin
        next_st.rdata = st.boot_select_option[15:8];
      end
      else if (opt_hit[6])
      begin
        next_st.rdata = st.boot_select_option[7:0];
      end
      else
      begin
        next_st.rdata = 8'h00;
      end
    end
    // Readout protection from live lock byte
    next_st.readout_protect = (st.readout_lock_live != `OBD_UNLOCK_VALUE);
    next_st.boot_protect = next_mask;
    // Main array key sequence
    case (st.key_state)
      obd_pkg::OBD_KEY_IDLE:
      begin
        if (key_wr && key_data == `OBD_KEY_FIRST)
        begin
          next_st.key_state = obd_pkg::OBD_KEY_HALF;
        end
      end
      obd_pkg::OBD_KEY_HALF:
      begin
        if (key_wr)
        begin
          if (key_data == `OBD_KEY_SECOND)
          begin
            next_st.key_state = obd_pkg::OBD_KEY_OPEN;
          end
          else
          begin
            next_st.key_state = obd_pkg::OBD_KEY_IDLE;
          end
        end
      end
      default:
      begin
        if (main_relock)
        begin
          next_st.key_state = obd_pkg::OBD_KEY_IDLE;
        end
      end
    endcase
    // Size option never touches the main array lock
    next_st.main_locked = (next_st.key_state != obd_pkg::OBD_KEY_OPEN);
    // Watchdog options, applied on the fly
    next_st.dog.indep_dog_hw_start = st.watchdog_option[`OBD_WD_IHW];
    next_st.dog.indep_dog_halt_stop = st.watchdog_option[`OBD_WD_IHALT];
    next_st.dog.window_dog_hw_start = st.watchdog_option[`OBD_WD_WHW];
    next_st.dog.window_dog_halt_reset = st.watchdog_option[`OBD_WD_WHALT];
    // Oscillator settle counts
    next_st.osc.fast_osc_settle_count = settle_cycles(st.oscillator_settle_option[1:0]);
    next_st.osc.slow_osc_settle_count = settle_cycles(st.oscillator_settle_option[3:2]);
    // Brownout settings
    next_st.bor.brownout_enable = st.brownout_option[`OBD_BO_EN];
    next_st.bor.brownout_level = st.brownout_option[`OBD_BO_LVL_HI:`OBD_BO_LVL_LO];
    // Boot decision, once per reset
    if (!st.boot_decided)
    begin
      next_st.boot_decided = 1'b1;
      next_st.boot_to_loader = (st.boot_select_option == `OBD_BOOT_KEY) ||
                               (reset_vector_byte != `OBD_VECTOR_VALID);
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.readout_lock_option <= `OBD_RST_READOUT;
      st.boot_area_size_option <= `OBD_RST_BOOTSIZE;
      st.watchdog_option <= `OBD_RST_WATCHDOG;
      st.oscillator_settle_option <= `OBD_RST_OSC;
      st.brownout_option <= `OBD_RST_BROWNOUT;
      st.boot_select_option <= `OBD_RST_BSEL;
      st.readout_lock_live <= `OBD_RST_READOUT;
      st.boot_area_size_live <= `OBD_RST_BOOTSIZE;
      st.key_state <= obd_pkg::OBD_KEY_IDLE;
      st.main_locked <= 1'b1;
      st.osc.fast_osc_settle_count <= `OBD_SETTLE_0;
      st.osc.slow_osc_settle_count <= `OBD_SETTLE_0;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign opt_rdata = st.rdata;
  assign readout_protect = st.readout_protect;
  assign boot_protect = st.boot_protect;
  assign main_locked = st.main_locked;
  assign dog_cfg = st.dog;
  assign osc_cfg = st.osc;
  assign bor_cfg = st.bor;
  assign boot_decided = st.boot_decided;
  assign boot_to_loader = st.boot_to_loader;

endmodule

// ==== sim/obd_option_decoder_asserts.sv ====
// Port checker for the option byte decoder.
// Assumes it is bound to obd_option_decoder.
`timescale 1ns/1ps
module obd_option_decoder_asserts
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic opt_wr,
  input wire logic opt_rd,
  input wire logic [15:0] opt_addr,
  input wire logic [7:0] opt_wdata,
  input wire logic opt_from_debug,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic main_relock,
  input wire logic [7:0] reset_vector_byte,
  input wire logic [7:0] opt_rdata,
  input wire logic readout_protect,
  input wire logic [127:0] boot_protect,
  input wire logic main_locked,
  input wire obd_pkg::obd_dog_type dog_cfg,
  input wire obd_pkg::obd_osc_type osc_cfg,
  input wire obd_pkg::obd_bor_type bor_cfg,
  input wire logic boot_decided,
  input wire logic boot_to_loader
);
  logic prev_rst_n;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clock)
  begin
    prev_rst_n <= rst_n;
  end
  function automatic logic [12:0] settle(input logic [1:0] c);
    return (c == 2'h0) ? 13'h0001 : (c == 2'h1) ? 13'h0010 : (c == 2'h2) ? 13'h0200 : 13'h1000;
  endfunction
  function automatic logic [127:0] pages(input logic [7:0] s);
    return (s >= 8'h7F) ? {128{1'b1}} : ((128'h1 << s) - 128'h1);
  endfunction
  // ----------------------------------------
  // Write then two quiet enabled cycles
  // ----------------------------------------
  sequence opt_put(logic [15:0] a);
    clk_en && opt_wr && opt_addr == a;
  endsequence
  sequence quiet2;
    (clk_en && !opt_wr)[*2];
  endsequence
  AST_LOCK: assert property (opt_put(16'h4800) ##0 opt_from_debug ##1 quiet2 |=>
    readout_protect == ($past(opt_wdata, 3) != 8'hAA)) else $error("lock decode wrong");
  AST_SIZE: assert property (opt_put(16'h4802) ##0 opt_from_debug ##1 quiet2 |=>
    boot_protect == pages($past(opt_wdata, 3))) else $error("page mask wrong");
  AST_DOG: assert property (opt_put(16'h4808) ##1 quiet2 |=> dog_cfg ==
    {$past(opt_wdata[0], 3), $past(opt_wdata[1], 3), $past(opt_wdata[2], 3),
    $past(opt_wdata[3], 3)}) else $error("watchdog decode wrong");
  AST_OSC: assert property (opt_put(16'h4809) ##1 quiet2 |=> osc_cfg ==
    {settle($past(opt_wdata[1:0], 3)), settle($past(opt_wdata[3:2], 3))})
    else $error("settle decode wrong");
  AST_BOR: assert property (opt_put(16'h480A) ##1 quiet2 |=>
    bor_cfg == {$past(opt_wdata[0], 3), $past(opt_wdata[3:1], 3)}) else $error("brownout wrong");
  AST_BOOT: assert property (!prev_rst_n && clk_en |=> boot_decided &&
    (boot_to_loader == ($past(reset_vector_byte) != 8'h82))) else $error("boot decision wrong");
  AST_RELOCK: assert property (clk_en && main_relock && !key_wr |=> main_locked)
    else $error("relock missed");
  AST_UNLOCK: assert property ($fell(main_locked) |->
    $past(clk_en && key_wr && key_data == 8'hA5)) else $error("unlock without key");
endmodule
bind obd_option_decoder obd_option_decoder_asserts u_chk (.clock(clock), .rst_n(rst_n),
  .clk_en(clk_en), .opt_wr(opt_wr), .opt_rd(opt_rd), .opt_addr(opt_addr),
  .opt_wdata(opt_wdata), .opt_from_debug(opt_from_debug), .key_wr(key_wr),
  .key_data(key_data), .main_relock(main_relock), .reset_vector_byte(reset_vector_byte),
  .opt_rdata(opt_rdata), .readout_protect(readout_protect), .boot_protect(boot_protect),
  .main_locked(main_locked), .dog_cfg(dog_cfg), .osc_cfg(osc_cfg), .bor_cfg(bor_cfg),
  .boot_decided(boot_decided), .boot_to_loader(boot_to_loader));

// ==== sim/tb_top.sv ====
// Self-checking bench for the option byte decoder.
// Assumes the package and checker are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic opt_wr = 1'b0;
  logic opt_rd = 1'b0;
  logic [15:0] opt_addr = 16'h0000;
  logic [7:0] opt_wdata = 8'h00;
  logic opt_from_debug = 1'b0;
  logic key_wr = 1'b0;
  logic [7:0] key_data = 8'h00;
  logic main_relock = 1'b0;
  logic [7:0] reset_vector_byte = 8'h82;
  logic [7:0] opt_rdata;
  logic readout_protect;
  logic [127:0] boot_protect;
  logic main_locked;
  obd_pkg::obd_dog_type dog_cfg;
  obd_pkg::obd_osc_type osc_cfg;
  obd_pkg::obd_bor_type bor_cfg;
  logic boot_decided;
  logic boot_to_loader;
  logic [7:0] rv;
  logic [7:0] sz [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h7E, 8'h7F, 8'h80, 8'hFF};
  int bad_count = 0;
  int check_count = 0;
  obd_option_decoder DUT (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .opt_wr(opt_wr),
    .opt_rd(opt_rd), .opt_addr(opt_addr), .opt_wdata(opt_wdata),
    .opt_from_debug(opt_from_debug), .key_wr(key_wr), .key_data(key_data),
    .main_relock(main_relock), .reset_vector_byte(reset_vector_byte), .opt_rdata(opt_rdata),
    .readout_protect(readout_protect), .boot_protect(boot_protect), .main_locked(main_locked),
    .dog_cfg(dog_cfg), .osc_cfg(osc_cfg), .bor_cfg(bor_cfg), .boot_decided(boot_decided),
    .boot_to_loader(boot_to_loader));
  initial
  begin
    forever #5 clock = ~clock;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [12:0] settle(input logic [1:0] c);
    return (c == 2'h0) ? 13'h0001 : (c == 2'h1) ? 13'h0010 : (c == 2'h2) ? 13'h0200 : 13'h1000;
  endfunction
  task chk(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d, input logic dbg);
    @(negedge clock);
    opt_wr = 1'b1;
    opt_addr = a;
    opt_wdata = d;
    opt_from_debug = dbg;
    @(negedge clock);
    opt_wr = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  task rd(input logic [15:0] a);
    @(negedge clock);
    opt_rd = 1'b1;
    opt_addr = a;
    @(negedge clock);
    opt_rd = 1'b0;
    @(negedge clock);
    rv = opt_rdata;
  endtask
  task key(input logic [7:0] d);
    @(negedge clock);
    key_wr = 1'b1;
    key_data = d;
  endtask
  task idle;
    @(negedge clock);
    key_wr = 1'b0;
    main_relock = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_defaults;
    rd(16'h4800);
    chk(rv, 8'hAA);
    wr(16'h4807, 8'hFF, 1'b0);
    rd(16'h4807);
    chk(rv, 8'h00);
    chk(readout_protect, 1'b0);
    chk(boot_protect, 128'h0);
    chk(osc_cfg, {13'h0001, 13'h0001});
    chk({boot_decided, boot_to_loader}, 2'h2);
    wr(16'h480B, 8'h55, 1'b0);
    wr(16'h480C, 8'hAA, 1'b0);
    rd(16'h480B);
    chk(rv, 8'h55);
    rd(16'h480C);
    chk(rv, 8'hAA);
    rd(16'h4801);
    chk(rv, 8'h00);
  endtask
  task t_lock;
    logic [7:0] v [4] = '{8'h00, 8'h55, 8'hAB, 8'hAA};
    foreach (v[i])
    begin
      wr(16'h4800, v[i], 1'b1);
      chk(readout_protect, v[i] != 8'hAA);
    end
    wr(16'h4800, 8'h00, 1'b0);
    chk(readout_protect, 1'b0);
    rd(16'h4800);
    chk(rv, 8'h00);
  endtask
  task t_size;
    logic [127:0] m;
    foreach (sz[i])
    begin
      wr(16'h4802, sz[i], 1'b1);
      m = (sz[i] >= 8'h7F) ? {128{1'b1}} : ((128'h1 << sz[i]) - 128'h1);
      chk(boot_protect, m);
    end
    wr(16'h4802, 8'h01, 1'b0);
    chk(main_locked, 1'b1);
    chk(boot_protect, {128{1'b1}});
    rd(16'h4802);
    chk(rv, 8'h01);
  endtask
  task t_fields;
    logic [7:0] b;
    for (int i = 0; i < 16; i++)
    begin
      b = {4'hA, i[3:0]};
      wr(16'h4808, b, 1'b0);
      wr(16'h4809, b, 1'b0);
      wr(16'h480A, b, 1'b0);
      chk(dog_cfg, {b[0], b[1], b[2], b[3]});
      chk(osc_cfg, {settle(b[1:0]), settle(b[3:2])});
      chk(bor_cfg, {b[0], b[3:1]});
      rd(16'h480A);
      chk(rv, {4'h0, b[3:0]});
    end
    clk_en = 1'b0;
    wr(16'h4808, 8'h00, 1'b0);
    clk_en = 1'b1;
    repeat (3) @(negedge clock);
    chk(dog_cfg, 4'hF);
  endtask
  task t_keys;
    key(8'h5A);
    key(8'hA5);
    idle;
    chk(main_locked, 1'b0);
    @(negedge clock);
    main_relock = 1'b1;
    idle;
    chk(main_locked, 1'b1);
    key(8'h5A);
    key(8'h11);
    idle;
    key(8'hA5);
    idle;
    chk(main_locked, 1'b1);
  endtask
  task t_boot;
    reset_vector_byte = 8'h00;
    @(negedge clock);
    rst_n = 1'b0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    chk({boot_decided, boot_to_loader}, 2'h3);
    chk(dog_cfg, 4'h0);
    rd(16'h480B);
    chk(rv, 8'h00);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    t_defaults;
    t_lock;
    t_size;
    t_fields;
    t_keys;
    t_boot;
    close_out;
  end
  initial
  begin
    #100000;
    bad_count++;
    close_out;
  end
endmodule
